/* src/mpc_output_ctl.sv */
// software output override, generator C timebase and current-status buffering
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`include "mpc_defs.svh"

// Summary of operation
// (RQ1) overridden pins follow software level bits
// (RQ2) odd bit complements even partner when complementary
// (RQ3) deadtime sample readable, writes ignored
// (RQ4) counter register reads counter, ignores writes
// (RQ5) modulus writable only with multiple timebase
// (RQ6) software never writes a zero modulus
// (RQ7) modulus buffered until load-ok and load
// (RQ8) modulus read returns the buffered value
// (RQ9) deadtime writable with timebase, frozen by protect
// (RQ10) current status applies from following period only
// (RQ11) odd value registers govern before first sample
// (RQ12) counter advances per tick, wraps at modulus
module mpc_output_ctl (
  // clock, reset, clock enable
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  input wire logic I_CE,
  // register port
  input wire mpc_pkg::mpc_addr_t I_ADDR,
  input wire mpc_pkg::mpc_word_t I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output mpc_pkg::mpc_word_t O_RDATA,
  // rest of the unit
  input wire logic I_PWM_TICK,
  input wire mpc_pkg::mpc_chan_t I_GEN_PWM,
  input wire logic [7:0] I_DT_SAMPLE,
  input wire mpc_pkg::mpc_pair_t I_CURRENT_SENSE_INPUT,
  // pins and state toward the unit
  output mpc_pkg::mpc_chan_t O_PWM,
  output mpc_pkg::mpc_pair_t O_PAIR_ODD_SEL,
  output logic O_LOAD_C,
  output mpc_pkg::mpc_cnt_t O_MOD_C_ACTIVE,
  output mpc_pkg::mpc_word_t O_DT_C,
  output logic O_TIMEBASE_MULTI,
  output logic O_RUN
);
  import mpc_pkg::*;

  mpc_chan_t sw_out;
  mpc_chan_t ovr_en;
  mpc_cnt_t mod_buf;
  mpc_cnt_t mod_act;
  mpc_cnt_t cnt;
  mpc_word_t dtmc;
  logic run;
  logic multiple_timebase_select;
  logic ldok;
  logic wp;
  logic indep;
  logic csc;
  mpc_pair_t cs_lat;
  mpc_pair_t cs_act;
  logic cs_seen;
  logic cs_valid;
  logic cnt_end;
  logic load_evt;
  logic wr_ctrl;
  mpc_chan_t next_pwm;
  mpc_pair_t next_sel;
  mpc_word_t next_rdata;

  assign wr_ctrl = I_CE && I_WR && (I_ADDR == `MPC_ADDR_CTRL);
  // a zero modulus ends every tick instead of hanging the counter
  assign cnt_end = ({1'b0, cnt} + 16'h0001) >= {1'b0, mod_act}; // RQ6
  assign load_evt = I_CE && run && I_PWM_TICK && cnt_end; // RQ12

  // software output levels and override enables
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      sw_out <= `MPC_RST_OUT_LEVELS;
      ovr_en <= `MPC_RST_OVR_ENABLE;
    end else if (I_CE && I_WR) begin
      if (I_ADDR == `MPC_ADDR_OUT_LEVELS) begin
        sw_out <= I_WDATA[5:0];
      end
      if (I_ADDR == `MPC_ADDR_OVR_ENABLE) begin
        ovr_en <= I_WDATA[5:0];
      end
    end
  end

  // control bits; a software write of load-ok wins over the hardware clear
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      run <= 1'b0;
      multiple_timebase_select <= 1'b0;
      ldok <= 1'b0;
      wp <= 1'b0;
      indep <= 1'b0;
      csc <= 1'b0;
    end else if (I_CE) begin
      if (wr_ctrl) begin
        run <= I_WDATA[`MPC_CTRL_RUN];
        multiple_timebase_select <= I_WDATA[`MPC_CTRL_MTG];
        ldok <= I_WDATA[`MPC_CTRL_LDOK];
        // protect is sticky until reset
        wp <= wp | I_WDATA[`MPC_CTRL_WP];
        indep <= I_WDATA[`MPC_CTRL_INDEP];
        csc <= I_WDATA[`MPC_CTRL_CSC];
      end else if (load_evt) begin
        ldok <= 1'b0; // RQ7
      end
    end
  end

  // modulus buffer and active period
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      mod_buf <= `MPC_RST_MOD_C;
      mod_act <= `MPC_RST_MOD_C;
    end else if (I_CE) begin
      if (I_WR && (I_ADDR == `MPC_ADDR_MOD_C) && multiple_timebase_select) begin
        mod_buf <= I_WDATA[14:0]; // RQ5
      end
      if (load_evt && ldok) begin
        mod_act <= mod_buf; // RQ7
      end
    end
  end

  // deadtime C register
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      dtmc <= `MPC_RST_DT_C;
    end else if (I_CE && I_WR && (I_ADDR == `MPC_ADDR_DT_C) && multiple_timebase_select && !wp) begin
      dtmc <= I_WDATA; // RQ9
    end
  end

  // generator C counter
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      cnt <= `MPC_RST_CNT_C;
    end else if (I_CE) begin
      if (!run) begin
        cnt <= `MPC_RST_CNT_C;
      end else if (load_evt) begin
        cnt <= `MPC_RST_CNT_C; // RQ12
      end else if (I_PWM_TICK) begin
        cnt <= cnt + 15'h0001; // RQ12
      end
    end
  end

  // current status: latched each tick, applied only at the period boundary
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      cs_lat <= `MPC_RST_PAIR_SEL;
      cs_act <= `MPC_RST_PAIR_SEL;
      cs_seen <= 1'b0;
      cs_valid <= 1'b0;
    end else if (I_CE) begin
      if (!run) begin
        cs_seen <= 1'b0;
        cs_valid <= 1'b0; // RQ11
      end else begin
        if (I_PWM_TICK) begin
          cs_lat <= I_CURRENT_SENSE_INPUT; // RQ10
          cs_seen <= 1'b1;
        end
        if (load_evt) begin
          cs_act <= cs_lat; // RQ10
          cs_valid <= cs_seen;
        end
      end
    end
  end

  // pin selection: override per pin, complement taken from the even pin's final level
  always_comb begin
    next_pwm = I_GEN_PWM;
    for (int k = 0; k < 3; k++) begin
      if (ovr_en[2 * k]) begin
        next_pwm[2 * k] = sw_out[2 * k]; // RQ1
      end
      if (ovr_en[2 * k + 1]) begin
        if (indep) begin
          next_pwm[2 * k + 1] = sw_out[2 * k + 1]; // RQ2
        end else begin
          next_pwm[2 * k + 1] = sw_out[2 * k + 1] & ~next_pwm[2 * k]; // RQ2
        end
      end
    end
  end

  // value register selection per pair, 1 picks the odd register
  always_comb begin
    if (!csc) begin
      next_sel = `MPC_RST_PAIR_SEL;
    end else if (!cs_valid) begin
      next_sel = `MPC_ALL_ODD_SEL; // RQ11
    end else begin
      next_sel = cs_act; // RQ10
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    next_rdata = 16'h0000;
    case (I_ADDR)
      `MPC_ADDR_OUT_LEVELS: next_rdata = {10'h000, sw_out};
      `MPC_ADDR_OVR_ENABLE: next_rdata = {10'h000, ovr_en};
      `MPC_ADDR_DT_SAMPLE: next_rdata = {8'h00, I_DT_SAMPLE}; // RQ3
      `MPC_ADDR_CNT_C: next_rdata = {1'b0, cnt}; // RQ4
      `MPC_ADDR_MOD_C: next_rdata = {1'b0, mod_buf}; // RQ8
      `MPC_ADDR_DT_C: next_rdata = dtmc;
      `MPC_ADDR_CTRL: next_rdata = {10'h000, csc, indep, wp, ldok, multiple_timebase_select, run};
      default: next_rdata = 16'h0000;
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_RDATA <= 16'h0000;
    end else if (I_CE) begin
      O_RDATA <= I_RD ? next_rdata : 16'h0000;
    end
  end

  // registered outputs toward pins and the unit
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_PWM <= 6'h00;
      O_PAIR_ODD_SEL <= `MPC_RST_PAIR_SEL;
      O_LOAD_C <= 1'b0;
      O_MOD_C_ACTIVE <= `MPC_RST_MOD_C;
      O_DT_C <= `MPC_RST_DT_C;
      O_TIMEBASE_MULTI <= 1'b0;
      O_RUN <= 1'b0;
    end else if (I_CE) begin
      O_PWM <= next_pwm; // RQ1
      O_PAIR_ODD_SEL <= next_sel;
      O_LOAD_C <= load_evt; // RQ12
      O_MOD_C_ACTIVE <= mod_act;
      O_DT_C <= dtmc;
      O_TIMEBASE_MULTI <= multiple_timebase_select;
      O_RUN <= run;
    end
  end

  default clocking mpc_cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (I_RST);

  ovr_even_pin_a : assert property ( // RQ1
    (I_CE && ovr_en[0]) |=> (O_PWM[0] == $past(sw_out[0])))
    else $error("overridden pin 0 does not follow its software level");

  comp_odd_pin_a : assert property ( // RQ2
    (I_CE && ovr_en[1] && !indep) |=> (O_PWM[1] == ($past(sw_out[1]) && !O_PWM[0])))
    else $error("odd pin is not the complement of its partner");

  dt_sample_read_a : assert property ( // RQ3
    (I_CE && I_RD && (I_ADDR == `MPC_ADDR_DT_SAMPLE))
      |=> (O_RDATA == {8'h00, $past(I_DT_SAMPLE)}))
    else $error("deadtime sample readback is wrong");

  cnt_read_a : assert property ( // RQ4
    (I_CE && I_RD && (I_ADDR == `MPC_ADDR_CNT_C)) |=> (O_RDATA == {1'b0, $past(cnt)}))
    else $error("counter read does not return the counter");

  mod_write_lock_a : assert property ( // RQ5
    (I_CE && I_WR && (I_ADDR == `MPC_ADDR_MOD_C) && !multiple_timebase_select) |=> $stable(mod_buf))
    else $error("modulus changed without multiple timebase");

  mod_defer_a : assert property ( // RQ7
    !(load_evt && ldok) |=> $stable(mod_act))
    else $error("active modulus changed outside a load cycle");

  mod_read_buf_a : assert property ( // RQ8
    (I_CE && I_RD && (I_ADDR == `MPC_ADDR_MOD_C)) |=> (O_RDATA == {1'b0, $past(mod_buf)}))
    else $error("modulus read does not return the buffer");

  dt_protect_a : assert property ( // RQ9
    (wp || !multiple_timebase_select) |=> $stable(dtmc))
    else $error("deadtime changed while locked");

  cs_hold_a : assert property ( // RQ10
    !load_evt |=> $stable(cs_act))
    else $error("current status applied inside a period");

  first_odd_sel_a : assert property ( // RQ11
    (I_CE && csc && !cs_valid) |=> (O_PAIR_ODD_SEL == `MPC_ALL_ODD_SEL))
    else $error("odd value registers not selected before first sample");

  cnt_wrap_a : assert property ( // RQ12
    load_evt |=> ((cnt == `MPC_RST_CNT_C) && O_LOAD_C))
    else $error("counter did not restart at the period end");

  gen_pass_pin_a : assert property ( // RQ1
    (I_CE && !ovr_en[2]) |=> (O_PWM[2] == $past(I_GEN_PWM[2])))
    else $error("pin 2 does not follow the generator when not overridden");

  indep_odd_pin_a : assert property ( // RQ2
    (I_CE && ovr_en[1] && indep) |=> (O_PWM[1] == $past(sw_out[1])))
    else $error("odd pin does not follow its level bit in independent mode");

  comp_pair_two_a : assert property ( // RQ2
    (I_CE && ovr_en[3] && !indep) |=> (O_PWM[3] == ($past(sw_out[3]) && !O_PWM[2])))
    else $error("pin 3 is not the complement of pin 2");

  mod_write_ok_a : assert property ( // RQ5
    (I_CE && I_WR && (I_ADDR == `MPC_ADDR_MOD_C) && multiple_timebase_select)
      |=> (mod_buf == $past(I_WDATA[14:0])))
    else $error("permitted modulus write was lost");

  mod_load_a : assert property ( // RQ7
    (load_evt && ldok) |=> (mod_act == $past(mod_buf)))
    else $error("buffered modulus not applied at the load cycle");

  ldok_clear_a : assert property ( // RQ7
    (load_evt && !wr_ctrl) |=> !ldok)
    else $error("load-ok not cleared by the load cycle");

  dt_write_ok_a : assert property ( // RQ9
    (I_CE && I_WR && (I_ADDR == `MPC_ADDR_DT_C) && multiple_timebase_select && !wp)
      |=> (dtmc == $past(I_WDATA)))
    else $error("permitted deadtime write was lost");

  wp_sticky_a : assert property ( // RQ9
    wp |=> wp)
    else $error("write protect released without reset");

  cs_apply_a : assert property ( // RQ10
    load_evt |=> (cs_act == $past(cs_lat)))
    else $error("latched current status not applied at the period end");

  sel_active_a : assert property ( // RQ10
    (I_CE && csc && cs_valid) |=> (O_PAIR_ODD_SEL == $past(cs_act)))
    else $error("pair selection does not follow the applied status");

  cs_restart_a : assert property ( // RQ11
    (I_CE && !run) |=> !cs_valid)
    else $error("status still valid after the generator stopped");

  cnt_step_a : assert property ( // RQ12
    (I_CE && run && I_PWM_TICK && !cnt_end) |=> (cnt == $past(cnt) + 15'h0001))
    else $error("counter did not advance on a tick");

  cnt_idle_a : assert property ( // RQ12
    (I_CE && !run) |=> (cnt == `MPC_RST_CNT_C))
    else $error("counter not held while stopped");

endmodule : mpc_output_ctl

/* common/mpc_defs.svh */
// register map, field positions and reset values of the generator C output block
`ifndef MPC_DEFS_SVH
`define MPC_DEFS_SVH

// register offsets
`define MPC_ADDR_OUT_LEVELS 8'h0D
`define MPC_ADDR_OVR_ENABLE 8'h0E
`define MPC_ADDR_DT_SAMPLE 8'h20
`define MPC_ADDR_CNT_C 8'h30
`define MPC_ADDR_MOD_C 8'h32
`define MPC_ADDR_DT_C 8'h34
`define MPC_ADDR_CTRL 8'h36

// control register fields
`define MPC_CTRL_RUN 0
`define MPC_CTRL_MTG 1
`define MPC_CTRL_LDOK 2
`define MPC_CTRL_WP 3
`define MPC_CTRL_INDEP 4
`define MPC_CTRL_CSC 5

// reset values
`define MPC_RST_OUT_LEVELS 6'h00
`define MPC_RST_OVR_ENABLE 6'h00
`define MPC_RST_MOD_C 15'h0001
`define MPC_RST_DT_C 16'h0000
`define MPC_RST_CNT_C 15'h0000
`define MPC_RST_PAIR_SEL 3'h0
`define MPC_ALL_ODD_SEL 3'h7

`endif

/* common/mpc_pkg.sv */
// types shared by the generator C output block
package mpc_pkg;
  typedef logic [7:0] mpc_addr_t;
  typedef logic [15:0] mpc_word_t;
  typedef logic [14:0] mpc_cnt_t;
  typedef logic [5:0] mpc_chan_t;
  typedef logic [2:0] mpc_pair_t;
endpackage : mpc_pkg

/* verification/mpc_tb.sv */
// self-checking bench for the generator C output block
`timescale 1ns/1ps
`include "mpc_defs.svh"
module testbench;
  import mpc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  mpc_addr_t addr = 8'h00;
  mpc_word_t wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic tck = 1'b0;
  mpc_chan_t gen = 6'h00;
  mpc_pair_t sense = 3'h0;
  logic ce = 1'b1;
  logic [7:0] dts = 8'hA5;
  mpc_word_t rdata;
  mpc_chan_t pwm;
  mpc_pair_t odd;
  logic load_c;
  mpc_cnt_t mod_act;
  mpc_word_t dt_c;
  logic tbm;
  logic run_o;
  int mismatches = 0;
  int n_compared = 0;
  int loads = 0;
  int l0;
  always #2 clk = ~clk;
  mpc_output_ctl i_dut (.I_CORE_CLK(clk), .I_RST(rst), .I_CE(ce), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_PWM_TICK(tck),
    .I_GEN_PWM(gen), .I_DT_SAMPLE(dts), .I_CURRENT_SENSE_INPUT(sense), .O_PWM(pwm),
    .O_PAIR_ODD_SEL(odd), .O_LOAD_C(load_c), .O_MOD_C_ACTIVE(mod_act), .O_DT_C(dt_c),
    .O_TIMEBASE_MULTI(tbm), .O_RUN(run_o));
  always @(posedge clk) if (load_c === 1'b1) loads <= loads + 1;
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr_reg(input mpc_addr_t a, input mpc_word_t d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  // read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd_chk(input string what, input mpc_addr_t a, input mpc_word_t exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(what, exp, rdata);
  endtask : rd_chk
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle
  // ticks are spaced by an idle cycle so each one is a clean single pulse
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk);
      tck <= 1'b1;
      @(posedge clk);
      tck <= 1'b0;
    end
    settle();
  endtask : pulse
  task automatic t_override;
    @(posedge clk);
    gen <= 6'h15;
    wr_reg(`MPC_ADDR_CTRL, 16'h0000);
    wr_reg(`MPC_ADDR_OUT_LEVELS, 16'h000E);
    wr_reg(`MPC_ADDR_OVR_ENABLE, 16'h0003);
    settle();
    chk("pins partial", 16'h0016, {10'h000, pwm});
    wr_reg(`MPC_ADDR_OVR_ENABLE, 16'h003F);
    settle();
    chk("pins compl", 16'h0006, {10'h000, pwm});
    wr_reg(`MPC_ADDR_CTRL, 16'h0010);
    settle();
    chk("pins indep", 16'h000E, {10'h000, pwm});
    rd_chk("levels", `MPC_ADDR_OUT_LEVELS, 16'h000E);
  endtask : t_override
  task automatic t_readonly;
    rd_chk("dt sample", `MPC_ADDR_DT_SAMPLE, 16'h00A5);
    wr_reg(`MPC_ADDR_DT_SAMPLE, 16'hFFFF);
    rd_chk("dt sample wr", `MPC_ADDR_DT_SAMPLE, 16'h00A5);
    @(posedge clk);
    dts <= 8'h5A;
    rd_chk("dt sample new", `MPC_ADDR_DT_SAMPLE, 16'h005A);
    wr_reg(8'h40, 16'hFFFF);
    rd_chk("unmapped", 8'h40, 16'h0000);
  endtask : t_readonly
  task automatic t_modulus;
    wr_reg(`MPC_ADDR_CTRL, 16'h0000);
    wr_reg(`MPC_ADDR_MOD_C, 16'h0005);
    rd_chk("mod no mtg", `MPC_ADDR_MOD_C, 16'h0001);
    chk("timebase off", 16'h0000, {15'h0000, tbm});
    wr_reg(`MPC_ADDR_CTRL, 16'h0002);
    wr_reg(`MPC_ADDR_MOD_C, 16'h8003);
    rd_chk("mod buffer", `MPC_ADDR_MOD_C, 16'h0003);
    chk("mod active", 16'h0001, {1'b0, mod_act});
    wr_reg(`MPC_ADDR_CTRL, 16'h0007);
    pulse(1);
    chk("mod loaded", 16'h0003, {1'b0, mod_act});
    chk("timebase on", 16'h0001, {15'h0000, tbm});
    chk("run on", 16'h0001, {15'h0000, run_o});
    l0 = loads;
    pulse(1);
    rd_chk("cnt 1", `MPC_ADDR_CNT_C, 16'h0001);
    wr_reg(`MPC_ADDR_CNT_C, 16'hFFFF);
    rd_chk("cnt wr", `MPC_ADDR_CNT_C, 16'h0001);
    pulse(1);
    rd_chk("cnt 2", `MPC_ADDR_CNT_C, 16'h0002);
    pulse(1);
    rd_chk("cnt wrap", `MPC_ADDR_CNT_C, 16'h0000);
    chk("load pulses", 16'h0001, 16'(loads - l0));
    // new period without load-ok: must stay buffered through the next load cycle
    wr_reg(`MPC_ADDR_MOD_C, 16'h0002);
  endtask : t_modulus
  task automatic t_status;
    wr_reg(`MPC_ADDR_CTRL, 16'h0002);
    settle();
    chk("odd off", 16'h0000, {13'h0000, odd});
    wr_reg(`MPC_ADDR_CTRL, 16'h0023);
    settle();
    chk("odd first", 16'h0007, {13'h0000, odd});
    @(posedge clk);
    sense <= 3'h2;
    pulse(1);
    chk("odd t1", 16'h0007, {13'h0000, odd});
    @(posedge clk);
    sense <= 3'h5;
    pulse(1);
    chk("odd t2", 16'h0007, {13'h0000, odd});
    pulse(1);
    chk("odd load", 16'h0005, {13'h0000, odd});
    chk("mod kept", 16'h0003, {1'b0, mod_act});
    rd_chk("mod differs", `MPC_ADDR_MOD_C, 16'h0002);
    @(posedge clk);
    sense <= 3'h2;
    pulse(1);
    chk("odd hold", 16'h0005, {13'h0000, odd});
  endtask : t_status
  // write protect sticks until reset, so this runs just before the reset test
  task automatic t_deadtime;
    wr_reg(`MPC_ADDR_CTRL, 16'h0000);
    wr_reg(`MPC_ADDR_DT_C, 16'hABCD);
    rd_chk("dt no mtg", `MPC_ADDR_DT_C, 16'h0000);
    wr_reg(`MPC_ADDR_CTRL, 16'h0002);
    wr_reg(`MPC_ADDR_DT_C, 16'h1234);
    rd_chk("dt mtg", `MPC_ADDR_DT_C, 16'h1234);
    chk("dt copy", 16'h1234, dt_c);
    wr_reg(`MPC_ADDR_CTRL, 16'h000A);
    wr_reg(`MPC_ADDR_DT_C, 16'h5555);
    rd_chk("dt protect", `MPC_ADDR_DT_C, 16'h1234);
    chk("dt copy kept", 16'h1234, dt_c);
    chk("run off", 16'h0000, {15'h0000, run_o});
  endtask : t_deadtime
  // ticks and writes while the clock enable is low must leave no trace
  task automatic t_freeze;
    @(posedge clk);
    ce <= 1'b0;
    pulse(2);
    wr_reg(`MPC_ADDR_OUT_LEVELS, 16'h0015);
    @(posedge clk);
    ce <= 1'b1;
    rd_chk("cnt frozen", `MPC_ADDR_CNT_C, 16'h0001);
    rd_chk("levels frozen", `MPC_ADDR_OUT_LEVELS, 16'h000E);
  endtask : t_freeze
  // a second reset with the generator stopped clears the sticky protect and all state
  task automatic t_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_chk("ctrl reset", `MPC_ADDR_CTRL, 16'h0000);
    rd_chk("mod reset", `MPC_ADDR_MOD_C, 16'h0001);
    chk("mod act reset", 16'h0001, {1'b0, mod_act});
    wr_reg(`MPC_ADDR_CTRL, 16'h0002);
    wr_reg(`MPC_ADDR_DT_C, 16'h0777);
    rd_chk("dt after reset", `MPC_ADDR_DT_C, 16'h0777);
  endtask : t_reset
  task automatic conclude;
    $display("mismatches %0d n_compared %0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_override();
    t_readonly();
    t_modulus();
    t_status();
    t_freeze();
    t_deadtime();
    t_reset();
    conclude();
  end
  initial begin
    #20000;
    mismatches++;
    conclude();
  end
endmodule : testbench
